// ===== design/scr_pkg.sv
package scr_pkg;
  // low-byte port addresses; upper address byte is ignored
  localparam logic [7:0] SCR_ADDR_CHA_CTRL = 8'he0;
  localparam logic [7:0] SCR_ADDR_CHA_DATA = 8'he1;
  localparam logic [7:0] SCR_ADDR_CHB_CTRL = 8'he2;
  localparam logic [7:0] SCR_ADDR_CHB_DATA = 8'he3;
  // register indices reached through the pointer
  localparam logic [3:0] SCR_REG_POINTER = 4'h0;
  localparam logic [3:0] SCR_REG_SRX_STATUS = 4'h1;
  localparam logic [3:0] SCR_REG_VECTOR = 4'h2;
  localparam logic [3:0] SCR_REG_PENDING = 4'h3;
  localparam logic [3:0] SCR_REG_RX_PARAM = 4'h3;
  localparam logic [3:0] SCR_REG_MODE = 4'h4;
  localparam logic [3:0] SCR_REG_TX_PARAM = 4'h5;
  localparam logic [3:0] SCR_REG_FS_CNT_LO = 4'h6;
  localparam logic [3:0] SCR_REG_FS_CNT_HI = 4'h7;
  localparam logic [3:0] SCR_REG_FLAG_EXT = 4'h7;
  localparam logic [3:0] SCR_REG_MASTER_IRQ = 4'h9;
  localparam logic [3:0] SCR_REG_MISC = 4'ha;
  localparam logic [3:0] SCR_REG_BAUD_LO = 4'hc;
  localparam logic [3:0] SCR_REG_BAUD_HI = 4'hd;
  localparam logic [3:0] SCR_REG_RB_FLAG = 4'he;
  localparam logic [3:0] SCR_REG_EXT_STATUS = 4'hf;
  // pointer command field: low three bits, bits 5:3 equal to 001 select the upper bank
  localparam int SCR_PTR_LSB = 0;
  localparam int SCR_PTR_W = 3;
  localparam int SCR_PTR_HIGH_CMD_LSB = 3;
  localparam logic [2:0] SCR_CMD_POINT_HIGH = 3'b001;
  // bit positions, reset byte, crc constants and frame status fifo sizes
  localparam int SCR_EXT_CRC32_BIT = 7;
  localparam int SCR_EXT_READBACK_BIT = 6;
  localparam int SCR_ESI_EXTEN_BIT = 0;
  localparam int SCR_ESI_FSFIFO_BIT = 2;
  localparam int SCR_SRX_CRC_BIT = 6;
  localparam int SCR_ENH_DIV2_BIT = 3;
  localparam int SCR_MISC_PRESET_BIT = 7;
  localparam logic [7:0] SCR_RESET_BYTE = 8'h00;
  localparam logic [31:0] SCR_CRC32_POLY = 32'h04c11db7;
  localparam logic [15:0] SCR_CRC16_POLY = 16'h1021;
  localparam logic [31:0] SCR_CRC32_RESIDUE = 32'hc704dd7b;
  localparam int SCR_FS_DEPTH = 10;
  localparam int SCR_FS_WIDTH = 19;
endpackage

// ===== design/scr_crc_unit.sv
`timescale 1ns/1ps
`default_nettype none
module scr_crc_unit
  import scr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic crc32_en,
  input wire logic preset_ones,
  input wire logic init,
  input wire logic bit_valid,
  input wire logic bit_in,
  // result
  output logic [31:0] crc_q,
  output logic match
);
  logic [31:0] crc_d;
  logic fb;
  // one shift register serves both widths, so only one crc runs at a time
  always_comb begin
    fb = crc32_en ? (crc_q[31] ^ bit_in) : (crc_q[15] ^ bit_in);
    crc_d = crc_q << 1;
    if (crc32_en) begin
      if (fb) begin
        crc_d = (crc_q << 1) ^ SCR_CRC32_POLY;
      end
    end else begin
      crc_d[31:16] = 16'h0000;
      if (fb) begin
        crc_d[15:0] = {crc_q[14:0], 1'b0} ^ SCR_CRC16_POLY;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_q <= 32'h00000000;
    end else if (init) begin
      crc_q <= preset_ones ? 32'hffffffff : 32'h00000000;
    end else if (bit_valid) begin
      crc_q <= crc_d;
    end
  end
  assign match = crc32_en ? (crc_q == SCR_CRC32_RESIDUE) : (crc_q[15:0] == 16'h0000);
endmodule
`default_nettype wire

// ===== design/scr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module scr_regs
  import scr_pkg::*;
#(
  parameter int FS_DEPTH = SCR_FS_DEPTH
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor i/o cycle
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_sel,
  // system configuration
  input wire logic emul_en,
  input wire logic [7:0] enh_wdata,
  input wire logic enh_wr,
  output logic [7:0] enh_q,
  // serial data path seen by the core
  input wire logic [1:0] rx_bit_valid,
  input wire logic [1:0] rx_bit,
  input wire logic [1:0] frame_start,
  input wire logic [1:0] frame_end,
  input wire logic [1:0] tx_bit_valid,
  input wire logic [1:0] tx_bit,
  input wire logic [7:0] irq_pending,
  input wire logic [3:0] vec_status,
  // channel b pins and emulation timers
  input wire logic chb_clk_core,
  output logic chb_pins_en,
  output logic emul_timer_clk,
  // core clocking and crc outputs
  output logic core_clk_en,
  output logic [1:0] crc32_active,
  output logic [1:0][31:0] tx_crc,
  output logic [1:0][15:0] fs_count
);
  // ==========================================================
  // address decode
  logic hit_ctrl, hit_data, chan, rd_ev, wr_ev;
  logic [7:0] low;
  assign low = io_addr[7:0];
  always_comb begin
    hit_ctrl = 1'b0;
    hit_data = 1'b0;
    chan = 1'b0;
    if (low == SCR_ADDR_CHA_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (low == SCR_ADDR_CHA_DATA) begin
      hit_data = 1'b1;
    end else if (low == SCR_ADDR_CHB_CTRL) begin
      hit_ctrl = 1'b1;
      chan = 1'b1;
    end else if (low == SCR_ADDR_CHB_DATA) begin
      hit_data = 1'b1;
      chan = 1'b1;
    end
  end
  assign io_sel = hit_ctrl | hit_data;
  assign wr_ev = io_wr & io_sel;
  assign rd_ev = io_rd & io_sel;

  // ==========================================================
  // pointer, one per channel
  logic [1:0][3:0] ptr_q;
  logic [3:0] cur_ptr;
  assign cur_ptr = ptr_q[chan];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_q <= '0;
    end else if ((wr_ev | rd_ev) && hit_ctrl) begin
      if (cur_ptr != SCR_REG_POINTER) begin
        ptr_q[chan] <= SCR_REG_POINTER;
      end else if (io_wr) begin
        ptr_q[chan] <= {io_wdata[5:SCR_PTR_HIGH_CMD_LSB] == SCR_CMD_POINT_HIGH,
                        io_wdata[SCR_PTR_LSB +: SCR_PTR_W]};
      end
    end
  end

  // ==========================================================
  // write registers: 16 per channel, vector and master irq shared
  logic [1:0][15:0][7:0] wreg_q;
  logic [7:0] vector_q, master_q;
  logic [1:0][7:0] ext_q, txbuf_q;
  logic ind_wr;
  assign ind_wr = wr_ev && hit_ctrl && cur_ptr != SCR_REG_POINTER;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wreg_q <= '0;
      vector_q <= SCR_RESET_BYTE;
      master_q <= SCR_RESET_BYTE;
    end else if (ind_wr) begin
      if (cur_ptr == SCR_REG_VECTOR) begin
        vector_q <= io_wdata;
      end else if (cur_ptr == SCR_REG_MASTER_IRQ) begin
        master_q <= io_wdata;
      end else if (!(cur_ptr == SCR_REG_FLAG_EXT && ext_sel)) begin
        // while unlocked, index 7 belongs to the extension register only
        wreg_q[chan][cur_ptr] <= io_wdata;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txbuf_q <= '0;
    end else if (wr_ev && hit_data) begin
      txbuf_q[chan] <= io_wdata;
    end
  end
  // extension register shares index 7 and is steered by the unlock bit
  logic ext_sel;
  assign ext_sel = wreg_q[chan][SCR_REG_EXT_STATUS][SCR_ESI_EXTEN_BIT];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_q <= '0;
    end else if (ind_wr && cur_ptr == SCR_REG_FLAG_EXT && ext_sel) begin
      ext_q[chan] <= io_wdata;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enh_q <= SCR_RESET_BYTE;
    end else if (enh_wr) begin
      enh_q <= enh_wdata;
    end
  end

  // ==========================================================
  // core clock enable: divide by 1 or 2
  logic div_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
    end
  end
  assign core_clk_en = enh_q[SCR_ENH_DIV2_BIT] ? div_q : 1'b1;

  // ==========================================================
  // channel b redirection under emulation
  assign chb_pins_en = ~emul_en;
  assign emul_timer_clk = emul_en & chb_clk_core;

  // ==========================================================
  // crc per channel and frame status fifo
  logic [1:0] rx_match;
  logic [1:0][7:0] srx_q;
  logic [1:0][FS_DEPTH-1:0][SCR_FS_WIDTH-1:0] fs_mem_q;
  logic [1:0][3:0] fs_wp_q;
  logic [1:0][15:0] byte_cnt_q;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      assign crc32_active[g] = ext_q[g][SCR_EXT_CRC32_BIT];
      scr_crc_unit u_rx (
        .clk(clk),
        .rst(rst),
        .crc32_en(crc32_active[g]),
        .preset_ones(wreg_q[g][SCR_REG_TX_PARAM][SCR_MISC_PRESET_BIT]),
        .init(frame_start[g]),
        .bit_valid(rx_bit_valid[g] & core_clk_en),
        .bit_in(rx_bit[g]),
        .crc_q(),
        .match(rx_match[g])
      );
      scr_crc_unit u_tx (
        .clk(clk),
        .rst(rst),
        .crc32_en(crc32_active[g]),
        .preset_ones(wreg_q[g][SCR_REG_TX_PARAM][SCR_MISC_PRESET_BIT]),
        .init(frame_start[g]),
        .bit_valid(tx_bit_valid[g] & core_clk_en),
        .bit_in(tx_bit[g]),
        .crc_q(tx_crc[g]),
        .match()
      );
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          srx_q[g] <= '0;
          byte_cnt_q[g] <= '0;
          fs_wp_q[g] <= '0;
          fs_mem_q[g] <= '0;
        end else begin
          if (frame_start[g]) begin
            byte_cnt_q[g] <= '0;
          end else if (rx_bit_valid[g] & core_clk_en) begin
            byte_cnt_q[g] <= byte_cnt_q[g] + 16'h0001;
          end
          if (frame_end[g]) begin
            srx_q[g][SCR_SRX_CRC_BIT] <= ~rx_match[g];
            fs_mem_q[g][fs_wp_q[g]] <= {crc32_active[g], ~rx_match[g], 1'b0, byte_cnt_q[g]};
            fs_wp_q[g] <= (fs_wp_q[g] == 4'(FS_DEPTH - 1)) ? 4'h0 : fs_wp_q[g] + 4'h1;
          end
        end
      end
      assign fs_count[g] = fs_mem_q[g][fs_wp_q[g] == 4'h0 ? 4'(FS_DEPTH - 1) : fs_wp_q[g] - 4'h1][15:0];
    end
  endgenerate

  // ==========================================================
  // read mux
  logic [7:0] rdata_d;
  logic readback, fs_ok;
  assign readback = ext_q[chan][SCR_EXT_READBACK_BIT];
  assign fs_ok = wreg_q[chan][SCR_REG_EXT_STATUS][SCR_ESI_FSFIFO_BIT];
  always_comb begin
    rdata_d = 8'h00;
    if (hit_data) begin
      rdata_d = txbuf_q[chan];
    end else if (cur_ptr == SCR_REG_POINTER) begin
      rdata_d = {4'h0, crc32_active[chan], chan, enh_q[SCR_ENH_DIV2_BIT], emul_en};
    end else if (cur_ptr == SCR_REG_SRX_STATUS) begin
      rdata_d = srx_q[chan];
    end else if (cur_ptr == SCR_REG_VECTOR) begin
      rdata_d = chan ? {vector_q[7:4], vec_status} : vector_q;
    end else if (cur_ptr == SCR_REG_PENDING) begin
      rdata_d = chan ? 8'h00 : irq_pending;
    end else if (cur_ptr == SCR_REG_FS_CNT_LO) begin
      rdata_d = fs_ok ? fs_count[chan][7:0] : 8'h00;
    end else if (cur_ptr == SCR_REG_FS_CNT_HI) begin
      rdata_d = fs_ok ? fs_count[chan][15:8] : 8'h00;
    end else if (cur_ptr == SCR_REG_MODE && readback) begin
      rdata_d = wreg_q[chan][SCR_REG_MODE];
    end else if (cur_ptr == SCR_REG_TX_PARAM && readback) begin
      rdata_d = wreg_q[chan][SCR_REG_TX_PARAM];
    end else if (cur_ptr == SCR_REG_MASTER_IRQ && readback) begin
      rdata_d = wreg_q[chan][SCR_REG_RX_PARAM];
    end else if (cur_ptr == SCR_REG_RB_FLAG && readback) begin
      rdata_d = ext_q[chan];
    end else if (cur_ptr == SCR_REG_BAUD_LO || cur_ptr == SCR_REG_BAUD_HI) begin
      rdata_d = wreg_q[chan][cur_ptr];
    end
  end
  // data output is registered: valid the cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_rdata <= 8'h00;
    end else if (rd_ev) begin
      io_rdata <= rdata_d;
    end
  end

  // ==========================================================
  // checks
  property p_ptr_clear;
    @(posedge clk) disable iff (rst)
      (wr_ev && hit_ctrl && cur_ptr != SCR_REG_POINTER) |=> (ptr_q[$past(chan)] == SCR_REG_POINTER);
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");
  property p_ext_lock;
    @(posedge clk) disable iff (rst)
      (ind_wr && cur_ptr == SCR_REG_FLAG_EXT && !ext_sel) |=> $stable(ext_q);
  endproperty
  a_ext_lock: assert property (p_ext_lock) else $error("locked extension written");
  property p_div1;
    @(posedge clk) disable iff (rst) !enh_q[SCR_ENH_DIV2_BIT] |-> core_clk_en;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one lost enable");
  sequence s_div2;
    enh_q[SCR_ENH_DIV2_BIT] && core_clk_en;
  endsequence
  property p_div2;
    @(posedge clk) disable iff (rst) s_div2 |=> !core_clk_en || !enh_q[SCR_ENH_DIV2_BIT];
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two enable twice");
  property p_emul;
    @(posedge clk) disable iff (rst) emul_en |-> !chb_pins_en;
  endproperty
  a_emul: assert property (p_emul) else $error("channel b pins still on");
  property p_pend_b;
    @(posedge clk) disable iff (rst)
      (rd_ev && chan && hit_ctrl && cur_ptr == SCR_REG_PENDING) |=> io_rdata == 8'h00;
  endproperty
  a_pend_b: assert property (p_pend_b) else $error("pending bits seen on b");
  property p_fs_gate;
    @(posedge clk) disable iff (rst)
      (rd_ev && hit_ctrl && !fs_ok && cur_ptr == SCR_REG_FS_CNT_LO) |=> io_rdata == 8'h00;
  endproperty
  a_fs_gate: assert property (p_fs_gate) else $error("fifo count read while gated");
  property p_alias;
    @(posedge clk) disable iff (rst) (io_addr[7:0] == SCR_ADDR_CHB_DATA) |-> io_sel && hit_data && chan;
  endproperty
  a_alias: assert property (p_alias) else $error("page alias decode fails");
  property p_ptr_load;
    @(posedge clk) disable iff (rst)
      (wr_ev && hit_ctrl && cur_ptr == SCR_REG_POINTER) |=> (ptr_q[$past(chan)][2:0] == $past(io_wdata[2:0]));
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
  property p_rd_clear;
    @(posedge clk) disable iff (rst)
      (rd_ev && hit_ctrl && cur_ptr != SCR_REG_POINTER) |=> (ptr_q[$past(chan)] == SCR_REG_POINTER);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("pointer not cleared after read");
  property p_ext_write;
    @(posedge clk) disable iff (rst)
      (ind_wr && cur_ptr == SCR_REG_FLAG_EXT && ext_sel) |=> (ext_q[$past(chan)] == $past(io_wdata));
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("unlocked extension not written");
  property p_data_direct;
    @(posedge clk) disable iff (rst)
      (wr_ev && hit_data) |=> (txbuf_q[$past(chan)] == $past(io_wdata));
  endproperty
  a_data_direct: assert property (p_data_direct) else $error("data port write lost");
  property p_vec_a;
    @(posedge clk) disable iff (rst)
      (rd_ev && hit_ctrl && !chan && cur_ptr == SCR_REG_VECTOR) |=> (io_rdata == $past(vector_q));
  endproperty
  a_vec_a: assert property (p_vec_a) else $error("vector on a is modified");
  property p_vec_b;
    @(posedge clk) disable iff (rst)
      (rd_ev && hit_ctrl && chan && cur_ptr == SCR_REG_VECTOR) |=> (io_rdata == {$past(vector_q[7:4]), $past(vec_status)});
  endproperty
  a_vec_b: assert property (p_vec_b) else $error("vector on b lacks status");
  property p_fs_gate_hi;
    @(posedge clk) disable iff (rst)
      (rd_ev && hit_ctrl && !fs_ok && cur_ptr == SCR_REG_FS_CNT_HI) |=> io_rdata == 8'h00;
  endproperty
  a_fs_gate_hi: assert property (p_fs_gate_hi) else $error("fifo high count read while gated");
  // read data must stand until the next read strobe
  property p_rd_stand;
    @(posedge clk) disable iff (rst) !rd_ev |=> $stable(io_rdata);
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data moved without a read");
endmodule
`default_nettype wire

// ===== test/scr_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// processor issuing one-cycle i/o strobes
module scr_cpu_model
  import scr_pkg::*;
(
  // clock
  input wire logic clk,
  // i/o cycle
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // released lines carry the inverse, so a stale value cannot pass for a fresh one
  task automatic put(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wr <= w;
    io_rd <= r;
    io_wdata <= d;
    if (w || r) begin
      @(posedge clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
    end
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    put(a, 1'b0, 1'b1, 8'h00);
    #1;
    q = io_rdata;
  endtask
  task automatic point(input logic [15:0] c, input logic [3:0] i);
    put(c, 1'b1, 1'b0, {2'b00, i[3] ? SCR_CMD_POINT_HIGH : 3'b000, i[2:0]});
  endtask
  task automatic wreg(input logic [15:0] c, input logic [3:0] i, input logic [7:0] d);
    point(c, i);
    put(c, 1'b1, 1'b0, d);
  endtask
  task automatic rreg(input logic [15:0] c, input logic [3:0] i, output logic [7:0] q);
    point(c, i);
    rd(c, q);
  endtask
endmodule
`default_nettype wire

// ===== test/serial_ctrl_register_access_crc32_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_register_access_crc32_tb
  import scr_pkg::*;
;
  // ==========================================
  // clock, reset and stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] io_addr;
  logic io_wr, io_rd, io_sel, chb_pins_en, emul_timer_clk, core_clk_en, c0;
  logic [7:0] io_wdata, io_rdata, enh_q, q, v, m, p;
  logic emul_en = 1'b0;
  logic [7:0] enh_wdata = 8'h00;
  logic enh_wr = 1'b0;
  logic [11:0] serial_in = 12'h000;
  // directed serial bits replace the noise while a checked frame runs
  logic [11:0] frame_bits = 12'h000;
  logic noise_on = 1'b1;
  logic [11:0] ser;
  logic [1:0][31:0] tx_crc;
  logic [1:0][15:0] fs_count;
  logic [31:0] ea, eb;
  assign ser = noise_on ? serial_in : frame_bits;
  logic [7:0] irq_pending = 8'h00;
  logic [3:0] vec_status = 4'h0;
  logic chb_clk_core = 1'b0;
  logic [1:0] crc32_active;
  logic [15:0] ca, cb;
  logic [31:0] seed = 32'hf71d6669;
  logic [31:0] nz = ~32'hf71d6669;
  int errors = 0;
  int comparisons = 0;
  int i;
  always #50 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] stat(input logic c, input logic ch, input logic dv, input logic em);
    return {4'h0, c, ch, dv, em};
  endfunction
  // serial crc step from the generator polynomial, most significant bit first
  function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic b, input logic wide);
    if (wide) begin
      return {c[30:0], 1'b0} ^ ((c[31] ^ b) ? SCR_CRC32_POLY : 32'h00000000);
    end
    return {16'h0000, {c[14:0], 1'b0} ^ ((c[15] ^ b) ? SCR_CRC16_POLY : 16'h0000)};
  endfunction
  // serial bits are noise here; they only keep the crc path moving
  always @(posedge clk) begin
    nz <= xs(nz);
    serial_in <= nz[11:0];
  end
  scr_cpu_model cpu (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata));
  scr_regs uut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_sel(io_sel), .emul_en(emul_en), .enh_wdata(enh_wdata), .enh_wr(enh_wr),
    .enh_q(enh_q), .rx_bit_valid(ser[1:0]), .rx_bit(ser[3:2]), .frame_start(ser[5:4]),
    .frame_end(ser[7:6]), .tx_bit_valid(ser[9:8]), .tx_bit(ser[11:10]),
    .irq_pending(irq_pending), .vec_status(vec_status), .chb_clk_core(chb_clk_core),
    .chb_pins_en(chb_pins_en), .emul_timer_clk(emul_timer_clk), .core_clk_en(core_clk_en),
    .crc32_active(crc32_active), .tx_crc(tx_crc), .fs_count(fs_count));
  // ==========================================
  // checking and verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    complete_run();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(enh_q, SCR_RESET_BYTE);
    chk({7'h0, core_clk_en}, 8'h01);
    chk({6'h0, crc32_active}, 8'h00);
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      cpu.put({seed[15:8], SCR_ADDR_CHA_CTRL + 8'(i)}, 1'b0, 1'b0, 8'h00);
      #1;
      chk({7'h0, io_sel}, {7'h0, i < 4});
    end
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      @(posedge clk);
      emul_en <= seed[0];
      chb_clk_core <= seed[1];
      #1;
      chk({6'h0, chb_pins_en, emul_timer_clk}, {6'h0, ~seed[0], seed[0] & seed[1]});
    end
    @(posedge clk);
    emul_en <= 1'b0;
    seed = xs(seed);
    ca = {seed[31:24], SCR_ADDR_CHA_CTRL};
    cb = {seed[23:16], SCR_ADDR_CHB_CTRL};
    v = seed[7:0];
    p = seed[15:8];
    irq_pending <= p;
    vec_status <= seed[19:16];
    cpu.wreg(cb, SCR_REG_VECTOR, v);
    cpu.rreg(ca, SCR_REG_VECTOR, q);
    chk(q, v);
    cpu.rreg(cb, SCR_REG_VECTOR, q);
    chk(q, {v[7:4], seed[19:16]});
    cpu.rreg(ca, SCR_REG_PENDING, q);
    chk(q, p);
    cpu.rreg(cb, SCR_REG_PENDING, q);
    chk(q, 8'h00);
    seed = xs(seed);
    m = seed[7:0];
    cpu.wreg(ca, SCR_REG_MODE, m);
    cpu.rd(ca, q);
    chk(q, stat(1'b0, 1'b0, 1'b0, 1'b0));
    // extension write must be ignored until the gate bit is on
    cpu.wreg(ca, SCR_REG_FLAG_EXT, 8'h80);
    @(posedge clk);
    #1;
    chk({6'h0, crc32_active}, 8'h00);
    cpu.rreg(ca, SCR_REG_FS_CNT_LO, q);
    chk(q, 8'h00);
    cpu.wreg(ca, SCR_REG_EXT_STATUS, 8'h01);
    cpu.wreg(ca, SCR_REG_FLAG_EXT, 8'hc0);
    @(posedge clk);
    #1;
    chk({6'h0, crc32_active}, 8'h01);
    cpu.rd(ca, q);
    chk(q, stat(1'b1, 1'b0, 1'b0, 1'b0));
    cpu.rd(cb, q);
    chk(q, stat(1'b0, 1'b1, 1'b0, 1'b0));
    cpu.rreg(ca, SCR_REG_MODE, q);
    chk(q, m);
    // directed frame: channel a on the 32-bit crc, channel b still on crc-16
    seed = xs(seed);
    ea = 32'h00000000;
    eb = 32'h00000000;
    @(posedge clk);
    noise_on <= 1'b0;
    frame_bits <= 12'h030;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      frame_bits <= {seed[i + 16], seed[i], 6'b110000, seed[i + 16], seed[i], 2'b11};
      ea = crc_ref(ea, seed[i], 1'b1);
      eb = crc_ref(eb, seed[i + 16], 1'b0);
    end
    @(posedge clk);
    frame_bits <= 12'h0c0;
    @(posedge clk);
    frame_bits <= 12'h000;
    @(posedge clk);
    #1;
    chk_word(tx_crc[0], ea);
    chk_word(tx_crc[1], eb);
    chk_word({16'h0000, fs_count[0]}, 32'h00000010);
    chk_word({16'h0000, fs_count[1]}, 32'h00000010);
    noise_on <= 1'b1;
    @(posedge clk);
    enh_wdata <= 8'h08;
    enh_wr <= 1'b1;
    @(posedge clk);
    enh_wr <= 1'b0;
    @(posedge clk);
    #1;
    chk(enh_q, 8'h08);
    c0 = core_clk_en;
    @(posedge clk);
    #1;
    chk({7'h0, core_clk_en ^ c0}, 8'h01);
    cpu.rd(ca, q);
    chk(q, stat(1'b1, 1'b0, 1'b1, 1'b0));
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk(enh_q, SCR_RESET_BYTE);
    chk({6'h0, crc32_active}, 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
